// File: hdl/ifb_pkg.sv
// Package for the interrupt flag and enable bank: offsets, field positions and carriers.
package ifb_pkg;

    // Register byte addresses on the AXI4-Lite bus.
    localparam logic [5:0] ADDR_EDGE   = 6'h00;
    localparam logic [5:0] ADDR_PRIM0  = 6'h04;
    localparam logic [5:0] ADDR_GRPSUM = 6'h08;
    localparam logic [5:0] ADDR_TICK   = 6'h0C;
    localparam logic [5:0] ADDR_GRP0   = 6'h10;
    localparam logic [5:0] ADDR_GRP1   = 6'h14;
    localparam logic [5:0] ADDR_GRP2   = 6'h18;
    localparam logic [5:0] ADDR_GRP3   = 6'h1C;
    localparam logic [5:0] ADDR_STAT   = 6'h20;
    localparam logic [5:0] ADDR_MASK   = 6'h24;
    localparam logic [5:0] ADDR_SVC    = 6'h28;

    // Implemented-bit masks.
    localparam logic [7:0] EDGE_MASK        = 8'h0F;
    localparam logic [7:0] PRIM0_MASK       = 8'h7F;
    localparam logic [7:0] GRPSUM_MASK_SML  = 8'h77;
    localparam logic [7:0] GRPSUM_MASK_LRG  = 8'hFF;
    localparam logic [7:0] TICK_MASK        = 8'h33;
    localparam logic [7:0] GRP1_MASK_SML    = 8'h77;
    localparam logic [7:0] GRP3_MASK        = 8'h33;
    localparam logic [7:0] FULL_MASK        = 8'hFF;
    localparam logic [7:0] ZERO_BYTE        = 8'h00;

    // Field positions shared by the flag and enable registers: flags high nibble, enables low.
    localparam int FLAG_LSB   = 4;
    localparam int GIE_BIT    = 0;
    localparam int PINB_SEL   = 2;
    localparam int PINA_SEL   = 0;
    localparam int CONV_FLAG  = 6;
    localparam int PINB_FLAG  = 5;
    localparam int PINA_FLAG  = 4;

    // Edge-select codes.
    localparam logic [1:0] EDGE_OFF  = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Events from peripherals, one-cycle pulses on clk_sys.
    typedef struct packed {
        logic       convDone;
        logic [1:0] tick;
        logic [3:0] grp0;
        logic [3:0] grp1;
        logic [3:0] grp2;
        logic [3:0] grp3;
    } ifb_events_t;

    // Service acknowledgement from the core.
    typedef struct packed {
        logic       valid;
        logic [3:0] source;
    } ifb_service_t;

    localparam logic [3:0] SRC_PINA = 4'h0;
    localparam logic [3:0] SRC_PINB = 4'h1;
    localparam logic [3:0] SRC_CONV = 4'h2;
    localparam logic [3:0] SRC_TB0  = 4'h3;
    localparam logic [3:0] SRC_TB1  = 4'h4;
    localparam logic [3:0] SRC_MF0  = 4'h8;

endpackage : ifb_pkg

// File: hdl/ifb_bank.sv
// Interrupt request flag and enable register bank with an AXI4-Lite slave.
// How it works
// - Bits 3..2 pick pin b edge.
// - Bits 1..0 pick pin a edge.
// - Edge register upper nibble reads zero.
// - First primary register layout, bit 7 zero.
// - Every source has flag and enable.
// - Small variant: three group summaries.
// - Large variant adds group three summary.
// - Time base flags 5..4, enables 1..0.
// - Small group zero: four timer matches.
// - Large group zero: timer two, zero.
// - Small group one: serial, sync, lowvolt.
// - Large group one: serial, timer one.
// - Global enable off blocks every irqPending request; irq is not gated.
// - Group two: timer, ext pin, serial.
// - Member event sets group summary flag.
// - Group service clears summary and global.
`timescale 1ns/1ps
module ifb_bank
    import ifb_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    // Clock and reset.
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // AXI4-Lite slave.
    input  wire logic [5:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [5:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // External pins, asynchronous.
    input  wire logic         ext_pin_a,
    input  wire logic         ext_pin_b,
    // Peripheral events and service acknowledge.
    input  wire ifb_events_t  events,
    input  wire ifb_service_t service,
    // Interrupt outputs.
    output logic [15:0]       irqPending,
    output logic              irq
);

    function automatic logic edgeHit(input logic [1:0] sel, input logic cur, input logic prev);
        edgeHit = ((sel == EDGE_RISE) && cur && !prev) || ((sel == EDGE_FALL) && !cur && prev)
                  || ((sel == EDGE_BOTH) && (cur != prev));
    endfunction : edgeHit

    localparam logic [7:0] GRPSUM_MASK = LARGE ? GRPSUM_MASK_LRG : GRPSUM_MASK_SML;
    localparam logic [7:0] GRP1_MASK   = LARGE ? FULL_MASK : GRP1_MASK_SML;
    localparam logic [7:0] GRP3_IMPL   = LARGE ? GRP3_MASK : ZERO_BYTE;
    localparam int         NGRP        = LARGE ? 4 : 3;

    logic [7:0] edgeSelectReg;
    logic [7:0] primaryIrqCtrl0;
    logic [7:0] groupSummaryCtrl;
    logic [7:0] timeBaseIrqCtrl;
    logic [7:0] groupReg [4];
    logic [7:0] evStatus;
    logic [7:0] evMask;

    // Pin synchronisers and edge history.
    logic [1:0] pinMeta;
    logic [1:0] pinSync;
    logic [1:0] pinPrev;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= 2'h0;
            pinSync <= 2'h0;
            pinPrev <= 2'h0;
        end else begin
            pinMeta <= {ext_pin_b, ext_pin_a};
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    logic pinAHit;
    logic pinBHit;
    assign pinAHit = edgeHit(edgeSelectReg[PINA_SEL +: 2], pinSync[0], pinPrev[0]);
    assign pinBHit = edgeHit(edgeSelectReg[PINB_SEL +: 2], pinSync[1], pinPrev[1]);

    // AXI write channel: address and data accepted in either order.
    logic        awHeld;
    logic        wHeld;
    logic [5:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        doWrite;
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 6'h00;
            wData         <= 32'h0000_0000;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr <= ADDR_SVC && !(awAddr == ADDR_GRP3 && !LARGE)
                                 && awAddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wrLane0;
    assign wrLane0 = doWrite && wStrb[0];
    function automatic logic wrHit(input logic [5:0] a, input logic [5:0] target, input logic en);
        wrHit = en && (a == target);
    endfunction : wrHit

    // Summary flag sets from group members that fire this cycle.
    logic [3:0] grpSet;
    always_comb begin
        grpSet = 4'h0;
        grpSet[0] = |events.grp0;
        // A member with no flag bit behind it must not raise its summary.
        grpSet[1] = |(events.grp1 & GRP1_MASK[7:FLAG_LSB]);
        grpSet[2] = |events.grp2;
        grpSet[3] = |(events.grp3 & GRP3_IMPL[7:FLAG_LSB]);
    end

    logic svcGroup;
    logic [1:0] svcIdx;
    assign svcGroup = service.valid && (service.source[3:2] == SRC_MF0[3:2]);
    assign svcIdx   = service.source[1:0];

    // Edge select register.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            edgeSelectReg <= ZERO_BYTE;
        end else if (wrHit(awAddr, ADDR_EDGE, wrLane0)) begin
            edgeSelectReg <= wData[7:0] & EDGE_MASK;
        end
    end

    // Primary control 0: hardware set wins over software write and service clear.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            primaryIrqCtrl0 <= ZERO_BYTE;
        end else begin
            logic [7:0] v;
            v = primaryIrqCtrl0;
            if (wrHit(awAddr, ADDR_PRIM0, wrLane0)) begin
                v = wData[7:0] & PRIM0_MASK;
            end
            if (service.valid) begin
                v[GIE_BIT] = 1'b0;
                if (service.source == SRC_PINA) v[PINA_FLAG] = 1'b0;
                if (service.source == SRC_PINB) v[PINB_FLAG] = 1'b0;
                if (service.source == SRC_CONV) v[CONV_FLAG] = 1'b0;
            end
            if (pinAHit) v[PINA_FLAG] = 1'b1;
            if (pinBHit) v[PINB_FLAG] = 1'b1;
            if (events.convDone) v[CONV_FLAG] = 1'b1;
            primaryIrqCtrl0 <= v;
        end
    end

    // Group summary register.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            groupSummaryCtrl <= ZERO_BYTE;
        end else begin
            logic [7:0] v;
            v = groupSummaryCtrl;
            if (wrHit(awAddr, ADDR_GRPSUM, wrLane0)) begin
                v = wData[7:0] & GRPSUM_MASK;
            end
            if (svcGroup) v[FLAG_LSB + svcIdx] = 1'b0;
            v[7:FLAG_LSB] = v[7:FLAG_LSB] | grpSet;
            groupSummaryCtrl <= v & GRPSUM_MASK;
        end
    end

    // Time base register.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timeBaseIrqCtrl <= ZERO_BYTE;
        end else begin
            logic [7:0] v;
            v = timeBaseIrqCtrl;
            if (wrHit(awAddr, ADDR_TICK, wrLane0)) v = wData[7:0];
            if (service.valid && service.source == SRC_TB0) v[FLAG_LSB] = 1'b0;
            if (service.valid && service.source == SRC_TB1) v[FLAG_LSB + 1] = 1'b0;
            v[FLAG_LSB +: 2] = v[FLAG_LSB +: 2] | events.tick;
            timeBaseIrqCtrl <= v & TICK_MASK;
        end
    end

    // Group member registers; member flags stay for software to clear.
    logic [3:0] grpEv [4];
    assign grpEv[0] = events.grp0;
    assign grpEv[1] = events.grp1;
    assign grpEv[2] = events.grp2;
    assign grpEv[3] = events.grp3;
    logic [7:0] grpMask [4];
    assign grpMask[0] = FULL_MASK;
    assign grpMask[1] = GRP1_MASK;
    assign grpMask[2] = FULL_MASK;
    assign grpMask[3] = GRP3_IMPL;

    for (genvar g = 0; g < 4; g++) begin : g_grp
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                groupReg[g] <= ZERO_BYTE;
            end else begin
                logic [7:0] v;
                v = groupReg[g];
                if (wrHit(awAddr, ADDR_GRP0 + 6'(4 * g), wrLane0)) v = wData[7:0];
                v[7:FLAG_LSB] = v[7:FLAG_LSB] | grpEv[g];
                groupReg[g] <= v & grpMask[g];
            end
        end
    end

    // Pending requests, gated by the global enable.
    logic [15:0] next_irqPending;
    always_comb begin
        next_irqPending = 16'h0000;
        next_irqPending[0] = primaryIrqCtrl0[PINA_FLAG] && primaryIrqCtrl0[1];
        next_irqPending[1] = primaryIrqCtrl0[PINB_FLAG] && primaryIrqCtrl0[2];
        next_irqPending[2] = primaryIrqCtrl0[CONV_FLAG] && primaryIrqCtrl0[3];
        next_irqPending[3] = timeBaseIrqCtrl[FLAG_LSB] && timeBaseIrqCtrl[0];
        next_irqPending[4] = timeBaseIrqCtrl[FLAG_LSB + 1] && timeBaseIrqCtrl[1];
        for (int i = 0; i < 4; i++) begin
            next_irqPending[8 + i] = groupSummaryCtrl[FLAG_LSB + i] && groupSummaryCtrl[i];
        end
        if (!primaryIrqCtrl0[GIE_BIT]) next_irqPending = 16'h0000;
    end

    // Event status: a read clears, a new event in the same cycle wins.
    logic rdStatus;
    logic [7:0] evNow;
    assign evNow = {2'h0, grpSet[1:0] != 2'h0, events.convDone, |events.tick,
                    |grpSet, pinBHit, pinAHit};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evStatus <= ZERO_BYTE;
            evMask   <= ZERO_BYTE;
        end else begin
            evStatus <= (rdStatus ? ZERO_BYTE : evStatus) | evNow;
            if (wrHit(awAddr, ADDR_MASK, wrLane0)) evMask <= wData[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irqPending <= 16'h0000;
            irq        <= 1'b0;
        end else begin
            irqPending <= next_irqPending;
            irq        <= |(evStatus & evMask);
        end
    end

    // AXI read channel.
    logic [7:0] rdByte;
    logic       rdOk;
    always_comb begin
        rdByte = ZERO_BYTE;
        rdOk   = 1'b1;
        unique case (s_axi_araddr)
            ADDR_EDGE:   rdByte = edgeSelectReg;
            ADDR_PRIM0:  rdByte = primaryIrqCtrl0;
            ADDR_GRPSUM: rdByte = groupSummaryCtrl;
            ADDR_TICK:   rdByte = timeBaseIrqCtrl;
            ADDR_GRP0:   rdByte = groupReg[0];
            ADDR_GRP1:   rdByte = groupReg[1];
            ADDR_GRP2:   rdByte = groupReg[2];
            ADDR_GRP3: begin
                rdByte = groupReg[3];
                rdOk   = LARGE;
            end
            ADDR_STAT:   rdByte = evStatus;
            ADDR_MASK:   rdByte = evMask;
            ADDR_SVC:    rdByte = ZERO_BYTE;
            default:     rdOk = 1'b0;
        endcase
    end

    assign rdStatus = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_STAT);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rdByte};
                s_axi_rresp  <= rdOk ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : ifb_bank

// File: verification/ifb_bank_assertions.sv
// Concurrent checks on the bus and interrupt ports of the flag and enable bank.
`timescale 1ns/1ps
module ifb_bank_assertions
    import ifb_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    // Clock and reset.
    input wire logic         clk_sys,
    input wire logic         rst_n,
    // Bus handshakes.
    input wire logic         s_axi_awvalid,
    input wire logic         s_axi_awready,
    input wire logic         s_axi_wvalid,
    input wire logic         s_axi_wready,
    input wire logic [1:0]   s_axi_bresp,
    input wire logic         s_axi_bvalid,
    input wire logic         s_axi_bready,
    input wire logic [5:0]   s_axi_araddr,
    input wire logic         s_axi_arvalid,
    input wire logic         s_axi_arready,
    input wire logic [31:0]  s_axi_rdata,
    input wire logic [1:0]   s_axi_rresp,
    input wire logic         s_axi_rvalid,
    input wire logic         s_axi_rready,
    // Core side.
    input wire ifb_service_t service,
    input wire logic [15:0]  irqPending
);
    logic [5:0] lastAr;

    // Read data is judged against the address taken for that same read.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lastAr <= 6'h00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            lastAr <= s_axi_araddr;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write response late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read response late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("address taken during response");
    property p_edge_top;
        s_axi_rvalid && lastAr == ADDR_EDGE |-> s_axi_rdata[7:4] == 4'h0;
    endproperty
    a_edge_top: assert property (p_edge_top) else $error("edge register top nibble set");
    property p_prim_top;
        s_axi_rvalid && lastAr == ADDR_PRIM0 |-> !s_axi_rdata[7];
    endproperty
    a_prim_top: assert property (p_prim_top) else $error("primary register bit 7 set");
    property p_tick_gap;
        s_axi_rvalid && lastAr == ADDR_TICK |-> (s_axi_rdata[7:0] & ~TICK_MASK) == 8'h00;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("time base gap bits set");
    property p_no_reg;
        s_axi_rvalid && (lastAr > ADDR_SVC || (!LARGE && lastAr == ADDR_GRP3))
            |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_no_reg: assert property (p_no_reg) else $error("missing register answered");
    property p_service;
        service.valid |-> ##[1:3] irqPending == 16'h0000;
    endproperty
    a_service: assert property (p_service) else $error("service left requests live");
endmodule : ifb_bank_assertions

bind ifb_bank ifb_bank_assertions #(.LARGE(LARGE)) i_chk (.clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .service, .irqPending);

// File: verification/ifb_periph_model.sv
// Stand-in for the peripherals, the core's service acknowledge and the two pins.
`timescale 1ns/1ps
module ifb_periph_model
    import ifb_pkg::*;
(
    // Clock.
    input wire logic     clk_sys,
    // Far-side outputs.
    output ifb_events_t  events,
    output ifb_service_t service,
    output logic         pinA,
    output logic         pinB
);
    initial begin
        events  = '0;
        service = '0;
        pinA    = 1'b0;
        pinB    = 1'b0;
    end

    // Pulses last one cycle; a held level would re-set a flag that software just cleared.
    task automatic fire(input ifb_events_t e);
        @(posedge clk_sys);
        events <= e;
        @(posedge clk_sys);
        events <= '0;
    endtask : fire

    task automatic serve(input logic [3:0] s);
        @(posedge clk_sys);
        service <= '{valid: 1'b1, source: s};
        @(posedge clk_sys);
        service <= '0;
    endtask : serve

    task automatic pin(input int p, input logic v);
        @(posedge clk_sys);
        if (p == 1) pinB <= v;
        else pinA <= v;
    endtask : pin
endmodule : ifb_periph_model

// File: verification/tb_top.sv
// Self-checking bench for the interrupt flag and enable bank.
`timescale 1ns/1ps
module tb_top
    import ifb_pkg::*;
;
    logic         clk_sys, rst_n;
    logic [5:0]   s_axi_awaddr, s_axi_araddr;
    logic [31:0]  s_axi_wdata, s_axi_rdata;
    logic [3:0]   s_axi_wstrb;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
    logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, extPinA, extPinB, irq;
    ifb_events_t  events;
    ifb_service_t service;
    logic [15:0]  irqPending;
    logic [7:0]   rdv, rdvSml;
    logic [31:0]  smlRdata;
    int           checks = 0, bad_count = 0, cyc = 0;

    ifb_bank i_dut (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ext_pin_a(extPinA), .ext_pin_b(extPinB), .events, .service, .irqPending, .irq);
    ifb_periph_model i_peri (.clk_sys, .events, .service, .pinA(extPinA), .pinB(extPinB));
    // The small layout shares every input; its handshakes match the large one, so only read data is watched.
    ifb_bank #(.LARGE(1'b0)) i_dut_sml (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(),
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(smlRdata),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .ext_pin_a(extPinA), .ext_pin_b(extPinB), .events,
        .service, .irqPending(), .irq());

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic results();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %0h expected %0h", $time, m, got, exp);
        end
    endtask : chk

    // Ready is registered, so its level at the falling edge is what the next rising edge samples.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic aw, w, b;
        b = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge clk_sys);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk_sys);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [5:0] a);
        logic ar, r;
        r = 1'b0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r) begin
            @(negedge clk_sys);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rdv = s_axi_rdata[7:0];
            rdvSml = smlRdata[7:0];
            rsp = s_axi_rresp;
            @(posedge clk_sys);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) s_axi_rready <= 1'b0;
        end
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    task automatic t_regs();
        logic [5:0] a[8];
        logic [7:0] m[8];
        logic [7:0] ms[8];
        a = '{ADDR_EDGE, ADDR_PRIM0, ADDR_GRPSUM, ADDR_TICK, ADDR_GRP0, ADDR_GRP1, ADDR_GRP2, ADDR_GRP3};
        m = '{EDGE_MASK, PRIM0_MASK, GRPSUM_MASK_LRG, TICK_MASK, FULL_MASK, FULL_MASK, FULL_MASK, GRP3_MASK};
        ms = '{EDGE_MASK, PRIM0_MASK, GRPSUM_MASK_SML, TICK_MASK, FULL_MASK, GRP1_MASK_SML, FULL_MASK, ZERO_BYTE};
        for (int k = 0; k < 8; k++) begin
            rd(a[k]);
            chk(rdv, 8'h00, "reset value");
            wr(a[k], 8'hFF);
            rd(a[k]);
            chk(rdv, m[k], "implemented bits");
            chk(rdvSml, ms[k], "small variant bits");
        end
        for (int k = 7; k >= 0; k--) wr(a[k], 8'h00);
        rd(6'h30);
        chk(rsp, RESP_SLVERR, "unmapped read answer");
        wr(6'h30, 8'hFF);
        chk(rsp, RESP_SLVERR, "unmapped write answer");
    endtask : t_regs

    task automatic t_events();
        logic [5:0] g;
        logic [7:0] want;
        for (int n = 0; n < 4; n++) begin
            for (int i = 0; i < 4; i++) begin
                g = ADDR_GRP0 + 6'(4 * n);
                i_peri.fire(ifb_events_t'(19'h1 << ((3 - n) * 4 + i)));
                want = (8'h10 << i) & (n == 3 ? GRP3_MASK : FULL_MASK);
                rd(g);
                chk(rdv, want, "member flag");
                rd(ADDR_GRPSUM);
                chk(rdv, want != 8'h00 ? 8'h10 << n : 8'h00, "summary flag");
                wr(g, 8'h00);
                wr(ADDR_GRPSUM, 8'h00);
            end
        end
        for (int t = 0; t < 3; t++) begin
            i_peri.fire(ifb_events_t'(19'h1 << (16 + t)));
            rd(t == 2 ? ADDR_PRIM0 : ADDR_TICK);
            chk(rdv, t == 2 ? 8'h40 : 8'h10 << t, "converter and time base flags");
            wr(ADDR_PRIM0, 8'h00);
            wr(ADDR_TICK, 8'h00);
        end
    endtask : t_events

    task automatic t_pins();
        logic [1:0] code;
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                code = 2'(c);
                wr(ADDR_EDGE, 8'(c) << (2 * p));
                wr(ADDR_PRIM0, 8'h00);
                i_peri.pin(p, 1'b1);
                settle(6);
                rd(ADDR_PRIM0);
                chk(rdv[4 + p], code[0], "rising edge flag");
                wr(ADDR_PRIM0, 8'h00);
                i_peri.pin(p, 1'b0);
                settle(6);
                rd(ADDR_PRIM0);
                chk(rdv[4 + p], code[1], "falling edge flag");
            end
        end
        wr(ADDR_EDGE, 8'h00);
        wr(ADDR_PRIM0, 8'h00);
    endtask : t_pins

    task automatic t_service();
        wr(ADDR_PRIM0, 8'h12);
        settle(3);
        chk(irqPending, 16'h0000, "global enable off");
        wr(ADDR_PRIM0, 8'h13);
        settle(3);
        chk(irqPending, 16'h0001, "pin request live");
        i_peri.serve(SRC_PINA);
        settle(3);
        chk(irqPending, 16'h0000, "pin serviced");
        rd(ADDR_PRIM0);
        chk(rdv, 8'h02, "pin flag and global enable cleared");
        wr(ADDR_GRP0, 8'h11);
        wr(ADDR_GRPSUM, 8'h11);
        wr(ADDR_PRIM0, 8'h01);
        settle(3);
        chk(irqPending, 16'h0100, "group request live");
        i_peri.serve(SRC_MF0);
        rd(ADDR_GRPSUM);
        chk(rdv, 8'h01, "summary cleared");
        rd(ADDR_GRP0);
        chk(rdv, 8'h11, "members kept");
        rd(ADDR_PRIM0);
        chk(rdv, 8'h00, "global enable cleared");
        wr(ADDR_GRP0, 8'h00);
        wr(ADDR_GRPSUM, 8'h00);
    endtask : t_service

    task automatic t_irq();
        rd(ADDR_STAT);
        wr(ADDR_MASK, 8'h10);
        i_peri.fire(ifb_events_t'(19'h1 << 18));
        settle(3);
        chk(irq, 1'b1, "unmasked event raises irq");
        wr(ADDR_MASK, 8'h00);
        settle(3);
        chk(irq, 1'b0, "masked event hides irq");
        rd(ADDR_STAT);
        chk(rdv, 8'h10, "status holds event");
        rd(ADDR_STAT);
        chk(rdv, 8'h00, "status read clears");
        wr(ADDR_MASK, 8'h10);
        settle(3);
        chk(irq, 1'b0, "cleared status keeps irq low");
    endtask : t_irq

    initial begin
        rst_n = 1'b0;
        s_axi_awaddr = 6'h00;
        s_axi_araddr = 6'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_events();
        t_pins();
        t_service();
        t_irq();
        results();
    end
endmodule : tb_top
